// ### rtl/bmss_pkg.sv
// How it works
// - low thermistor or high load-sense wakes device
// - ordered init steps, then normal mode
// - autonomous aux regulator on at 20 ms
// - boot started flag at 23 ms, alarm option
// - boot done and conversion flags at 47/35 ms
// - full pass flag at 97/62 ms, alarm option
// - switch decision only every 250 ms in normal
// - autonomous switches on at 278 ms
`default_nettype none
package bmss_pkg;

   // ********************************************************
   // clock and time base
   // ********************************************************
   localparam int unsigned CLK_PERIOD_PS = 4000; // 250 MHz
   localparam int unsigned MS_PS = 1000000000;
   // one millisecond in clock cycles, whole cycles only
   localparam int unsigned MS_CYCLES_DEF = MS_PS / CLK_PERIOD_PS;
   localparam int unsigned CYC_W = 18;
   localparam int unsigned MS_W = 10;
   localparam int unsigned DEC_W = 8;

   // ********************************************************
   // startup marks in milliseconds after wake
   // ********************************************************
   localparam logic [MS_W-1:0] AUX_REG_MS = 10'h014; // 20 ms
   localparam logic [MS_W-1:0] BOOT_START_MS = 10'h017; // 23 ms
   localparam logic [MS_W-1:0] BOOT_DONE_SLOW_MS = 10'h02F; // 47 ms
   localparam logic [MS_W-1:0] BOOT_DONE_FAST_MS = 10'h023; // 35 ms
   localparam logic [MS_W-1:0] FULL_PASS_SLOW_MS = 10'h061; // 97 ms
   localparam logic [MS_W-1:0] FULL_PASS_FAST_MS = 10'h03E; // 62 ms
   localparam logic [MS_W-1:0] SWITCH_ON_MS = 10'h116; // 278 ms
   localparam logic [DEC_W-1:0] DECISION_MS = 8'hFA; // 250 ms
   // decision ticks fall at SWITCH_ON_MS minus whole periods
   localparam logic [DEC_W-1:0] DECISION_PRELOAD =
      DECISION_MS - DEC_W'(SWITCH_ON_MS - MS_W'(DECISION_MS));

   // ********************************************************
   // values after reset
   // ********************************************************
   localparam logic [CYC_W-1:0] CYC_RST = 18'h00000;
   localparam logic [MS_W-1:0] MS_RST = 10'h000;
   localparam logic [DEC_W-1:0] DEC_RST = 8'h00;

   // ********************************************************
   // types
   // ********************************************************
   typedef enum logic [2:0] {
      ST_OFF = 3'h1,
      ST_BOOT = 3'h2,
      ST_NORMAL = 3'h4
   } bmss_state_t;

   typedef enum logic [1:0] {
      ALM_NONE = 2'h0,
      ALM_BOOT_STARTED = 2'h1,
      ALM_BOOT_DONE = 2'h2,
      ALM_FULL_PASS = 2'h3
   } bmss_alarm_sel_t;

endpackage
`default_nettype wire

// ### rtl/bmss_tb_if.sv
`timescale 1ns/10ps
`default_nettype none
// millisecond time base between sequencer and timer
interface bmss_tb_if;
   logic restart;
   logic ms_tick;
   logic [bmss_pkg::MS_W-1:0] ms_count;

   modport ctrl (
      output restart,
      input ms_tick,
      input ms_count
   );

   modport timer (
      input restart,
      output ms_tick,
      output ms_count
   );
endinterface
`default_nettype wire

// ### rtl/bmss_ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
module bmss_ms_timer #(
   parameter int unsigned MS_CYCLES = bmss_pkg::MS_CYCLES_DEF
)
(
   input wire logic mclk,
   input wire logic rst_n,
   bmss_tb_if.timer tb
);

   // ********************************************************
   // cycle and millisecond counters
   // ********************************************************
   localparam logic [bmss_pkg::CYC_W-1:0] CYC_LAST = bmss_pkg::CYC_W'(MS_CYCLES - 1);
   localparam logic [bmss_pkg::MS_W-1:0] MS_MAX = '1;

   logic [bmss_pkg::CYC_W-1:0] cyc_q;
   logic [bmss_pkg::CYC_W-1:0] cyc_d;
   logic [bmss_pkg::MS_W-1:0] ms_q;
   logic [bmss_pkg::MS_W-1:0] ms_d;
   logic tick_q;
   logic tick_d;
   wire logic wrap_w;

   // one millisecond elapses on the last cycle; count saturates
   assign wrap_w = (cyc_q == CYC_LAST);
   assign cyc_d = (tb.restart || wrap_w) ? bmss_pkg::CYC_RST : cyc_q + 1'b1;
   assign tick_d = wrap_w && !tb.restart;
   assign ms_d = tb.restart ? bmss_pkg::MS_RST :
                 (tick_q && ms_q != MS_MAX) ? ms_q + 1'b1 : ms_q;

   // registers
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cyc_q <= bmss_pkg::CYC_RST;
         ms_q <= bmss_pkg::MS_RST;
         tick_q <= 1'b0;
      end
      else
      begin
         cyc_q <= cyc_d;
         ms_q <= ms_d;
         tick_q <= tick_d;
      end
   end

   assign tb.ms_tick = tick_q;
   assign tb.ms_count = ms_q;

endmodule // bmss_ms_timer
`default_nettype wire

// ### rtl/bmss_startup_seq.sv
`timescale 1ns/10ps
`default_nettype none
module bmss_startup_seq #(
   parameter int unsigned MS_CYCLES = bmss_pkg::MS_CYCLES_DEF
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic thermistor_wake_pin,
   input wire logic load_sense_pin,
   input wire logic shutdown_req,
   input wire logic conversion_speed_select,
   input wire logic autonomous_switch_control,
   input wire logic aux_reg_autonomous,
   input wire logic [1:0] alarm_select,
   output logic aux_regulator_output,
   output logic boot_started_flag,
   output logic boot_done_flag,
   output logic conversion_pass_flag,
   output logic full_measurement_pass_flag,
   output logic normal_mode,
   output logic protection_switch_on,
   output logic alarm_o,
   output logic alarm_oe_n
);

   // ********************************************************
   // declarations
   // ********************************************************
   bmss_tb_if tb ();

   bmss_pkg::bmss_state_t state_q;
   bmss_pkg::bmss_state_t state_d;
   logic restart_q;
   logic restart_d;
   logic aux_q;
   logic aux_d;
   logic started_q;
   logic started_d;
   logic done_q;
   logic done_d;
   logic conv_q;
   logic conv_d;
   logic full_q;
   logic full_d;
   logic sw_q;
   logic sw_d;
   logic alarm_oe_n_q;
   logic alarm_oe_n_d;
   logic [bmss_pkg::DEC_W-1:0] dec_q;
   logic [bmss_pkg::DEC_W-1:0] dec_d;

   wire logic wake_w;
   wire logic off_w;
   wire logic running_w;
   wire logic hit_aux_w;
   wire logic hit_start_w;
   wire logic hit_done_w;
   wire logic hit_full_w;
   wire logic decision_w;
   wire logic alarm_active_w;
   wire logic [bmss_pkg::MS_W-1:0] done_mark_w;
   wire logic [bmss_pkg::MS_W-1:0] full_mark_w;

   // ********************************************************
   // time base
   // ********************************************************
   bmss_ms_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .tb(tb.timer)
   );

   assign tb.restart = restart_q;

   // true on the tick that moves the count onto the mark
   function automatic logic mark_hit(
      input logic tick,
      input logic [bmss_pkg::MS_W-1:0] count,
      input logic [bmss_pkg::MS_W-1:0] mark
   );
      mark_hit = tick && (count == mark - 1'b1);
   endfunction

   // ********************************************************
   // wake and sequence decoding
   // ********************************************************
   // either pin wakes the device from off
   assign wake_w = !thermistor_wake_pin || load_sense_pin;
   assign off_w = (state_q == bmss_pkg::ST_OFF);
   // the first restart cycle is time zero, so timing waits for it
   assign running_w = !off_w && !restart_q;

   // speed setting picks the earlier marks
   assign done_mark_w = conversion_speed_select ?
                        bmss_pkg::BOOT_DONE_FAST_MS : bmss_pkg::BOOT_DONE_SLOW_MS;
   assign full_mark_w = conversion_speed_select ?
                        bmss_pkg::FULL_PASS_FAST_MS : bmss_pkg::FULL_PASS_SLOW_MS;

   // marks reached on this millisecond tick
   assign hit_aux_w = running_w &&
                      mark_hit(tb.ms_tick, tb.ms_count, bmss_pkg::AUX_REG_MS);
   assign hit_start_w = running_w &&
                        mark_hit(tb.ms_tick, tb.ms_count, bmss_pkg::BOOT_START_MS);
   assign hit_done_w = running_w && mark_hit(tb.ms_tick, tb.ms_count, done_mark_w);
   assign hit_full_w = running_w && mark_hit(tb.ms_tick, tb.ms_count, full_mark_w);

   // decision slot every period, phased from wake
   assign decision_w = running_w && tb.ms_tick &&
                       (dec_q == bmss_pkg::DECISION_MS - 1'b1);

   // ********************************************************
   // state machine
   // ********************************************************
   // off, then boot steps, then normal once the full pass lands
   always_comb
   begin
      state_d = state_q;
      restart_d = 1'b0;
      case (state_q)
         bmss_pkg::ST_OFF:
         begin
            if (wake_w && !shutdown_req)
            begin
               state_d = bmss_pkg::ST_BOOT;
               restart_d = 1'b1;
            end
         end
         bmss_pkg::ST_BOOT:
         begin
            if (shutdown_req)
               state_d = bmss_pkg::ST_OFF;
            else if (hit_full_w)
               state_d = bmss_pkg::ST_NORMAL;
         end
         bmss_pkg::ST_NORMAL:
         begin
            if (shutdown_req)
               state_d = bmss_pkg::ST_OFF;
         end
         default:
         begin
            state_d = bmss_pkg::ST_OFF;
         end
      endcase
   end

   // ********************************************************
   // flags, regulator and switches
   // ********************************************************
   // flags stick until shutdown; all cleared when off
   assign aux_d = !off_w && (aux_q || (hit_aux_w && aux_reg_autonomous));
   assign started_d = !off_w && (started_q || hit_start_w);
   assign done_d = !off_w && (done_q || hit_done_w);
   assign conv_d = !off_w && (conv_q || hit_done_w);
   assign full_d = !off_w && (full_q || hit_full_w);
   // switches only turn on at a decision slot in normal mode; cleared when off
   assign sw_d = !off_w && (sw_q || (decision_w && autonomous_switch_control &&
                 state_q == bmss_pkg::ST_NORMAL));

   // decision phase counter restarts with every wake
   assign dec_d = restart_q ? bmss_pkg::DECISION_PRELOAD :
                  decision_w ? bmss_pkg::DEC_RST :
                  tb.ms_tick ? dec_q + 1'b1 : dec_q;

   // ********************************************************
   // alarm pin selection
   // ********************************************************
   // open drain: pulled low while the chosen flag is set
   assign alarm_active_w =
      (alarm_select == bmss_pkg::ALM_BOOT_STARTED && started_d) ||
      (alarm_select == bmss_pkg::ALM_BOOT_DONE && done_d) ||
      (alarm_select == bmss_pkg::ALM_FULL_PASS && full_d);
   assign alarm_oe_n_d = !alarm_active_w;

   // ********************************************************
   // registers
   // ********************************************************
   // control state
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= bmss_pkg::ST_OFF;
         restart_q <= 1'b0;
         dec_q <= bmss_pkg::DEC_RST;
      end
      else
      begin
         state_q <= state_d;
         restart_q <= restart_d;
         dec_q <= dec_d;
      end
   end

   // status outputs
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aux_q <= 1'b0;
         started_q <= 1'b0;
         done_q <= 1'b0;
         conv_q <= 1'b0;
         full_q <= 1'b0;
         sw_q <= 1'b0;
         alarm_oe_n_q <= 1'b1;
      end
      else
      begin
         aux_q <= aux_d;
         started_q <= started_d;
         done_q <= done_d;
         conv_q <= conv_d;
         full_q <= full_d;
         sw_q <= sw_d;
         alarm_oe_n_q <= alarm_oe_n_d;
      end
   end

   // mode output and constant low pin level, both from flops
   logic normal_q;
   logic alarm_lvl_q;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         normal_q <= 1'b0;
         alarm_lvl_q <= 1'b0;
      end
      else
      begin
         normal_q <= (state_d == bmss_pkg::ST_NORMAL);
         alarm_lvl_q <= 1'b0;
      end
   end

   // ********************************************************
   // outputs
   // ********************************************************
   assign aux_regulator_output = aux_q;
   assign boot_started_flag = started_q;
   assign boot_done_flag = done_q;
   assign conversion_pass_flag = conv_q;
   assign full_measurement_pass_flag = full_q;
   assign protection_switch_on = sw_q;
   assign normal_mode = normal_q;
   assign alarm_o = alarm_lvl_q;
   assign alarm_oe_n = alarm_oe_n_q;

endmodule // bmss_startup_seq
`default_nettype wire

// ### rtl/bmss_unused_guard.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ### dv/bmss_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// host side of the open-drain alarm pin
module bmss_host_model
(
   input wire logic mclk,
   input wire logic alarm_o,
   input wire logic alarm_oe_n,
   output logic alarm_line
);
   logic line_d;
   // pull-up holds the line high unless the device pulls it low
   assign line_d = alarm_oe_n ? 1'b1 : alarm_o;
   // host samples the line each clock
   always_ff @(posedge mclk)
   begin
      alarm_line <= line_d;
   end
endmodule // bmss_host_model
`default_nettype wire

// ### dv/bmss_startup_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module bmss_startup_seq_asserts #(
   parameter int unsigned MS_CYCLES = 4
)
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic thermistor_wake_pin,
   input wire logic load_sense_pin,
   input wire logic shutdown_req,
   input wire logic conversion_speed_select,
   input wire logic autonomous_switch_control,
   input wire logic aux_reg_autonomous,
   input wire logic [1:0] alarm_select,
   input wire logic aux_regulator_output,
   input wire logic boot_started_flag,
   input wire logic boot_done_flag,
   input wire logic conversion_pass_flag,
   input wire logic full_measurement_pass_flag,
   input wire logic normal_mode,
   input wire logic protection_switch_on,
   input wire logic alarm_o,
   input wire logic alarm_oe_n
);
   int unsigned gap_q;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // cycles spent with the aux regulator on
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         gap_q <= 0;
      else if (!aux_regulator_output)
         gap_q <= 0;
      else
         gap_q <= gap_q + 1;
   end
   a_shutdown_clears: assert property (shutdown_req |-> ##2 alarm_oe_n && !normal_mode)
      else $error("outputs not cleared after shutdown");
   a_flag_sticky: assert property (boot_started_flag && !shutdown_req && !$past(shutdown_req)
      |=> boot_started_flag) else $error("boot started flag dropped");
   a_done_order: assert property ($rose(boot_done_flag) |-> boot_started_flag)
      else $error("boot done before boot started");
   a_aux_enable: assert property ($rose(aux_regulator_output) |-> $past(aux_reg_autonomous))
      else $error("aux regulator on while not enabled");
   a_aux_gap: assert property ($rose(boot_started_flag) && aux_regulator_output
      |-> gap_q >= 3 * MS_CYCLES - 3 && gap_q <= 3 * MS_CYCLES + 1)
      else $error("aux to boot start gap wrong");
   a_alarm_level: assert property (alarm_o == 1'b0)
      else $error("alarm pin driven high");
   a_alarm_follows: assert property (!alarm_oe_n ==
      (($past(alarm_select) == 2'h1 && boot_started_flag) ||
       ($past(alarm_select) == 2'h2 && boot_done_flag) ||
       ($past(alarm_select) == 2'h3 && full_measurement_pass_flag)))
      else $error("alarm pin does not follow selected flag");
   a_done_pair: assert property ($rose(boot_done_flag) |-> $rose(conversion_pass_flag))
      else $error("conversion flag not paired");
   a_full_gap: assert property ($rose(boot_done_flag) |=> !full_measurement_pass_flag [*8])
      else $error("full pass too soon after boot done");
   a_full_normal: assert property ($rose(full_measurement_pass_flag) |-> normal_mode)
      else $error("full pass without normal mode");
   a_switch_cond: assert property ($rose(protection_switch_on)
      |-> normal_mode && $past(autonomous_switch_control)) else $error("switch on outside slot");
endmodule // bmss_startup_seq_asserts
bind bmss_startup_seq bmss_startup_seq_asserts #(.MS_CYCLES(MS_CYCLES)) bmss_startup_seq_asserts_i (
   .mclk(mclk), .rst_n(rst_n), .thermistor_wake_pin(thermistor_wake_pin),
   .load_sense_pin(load_sense_pin), .shutdown_req(shutdown_req),
   .conversion_speed_select(conversion_speed_select),
   .autonomous_switch_control(autonomous_switch_control),
   .aux_reg_autonomous(aux_reg_autonomous), .alarm_select(alarm_select),
   .aux_regulator_output(aux_regulator_output), .boot_started_flag(boot_started_flag),
   .boot_done_flag(boot_done_flag), .conversion_pass_flag(conversion_pass_flag),
   .full_measurement_pass_flag(full_measurement_pass_flag), .normal_mode(normal_mode),
   .protection_switch_on(protection_switch_on), .alarm_o(alarm_o), .alarm_oe_n(alarm_oe_n));
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int unsigned MS = 4;
   localparam logic [31:0] NONE = 32'hFFFFFFFF;
   logic mclk, rst_n, therm, ld, sd, spd, sw, aux_en, alarm_line;
   logic aux_o, st_f, dn_f, cv_f, fl_f, nm_o, sw_o, al_o, al_oe_n;
   logic [1:0] sel;
   logic [6:0] outs;
   logic [31:0] cyc = 32'h0;
   logic [31:0] seed;
   int bad_count = 0;
   int n_compared = 0;
   assign outs = {sw_o, nm_o, fl_f, cv_f, dn_f, st_f, aux_o};
   bmss_startup_seq #(.MS_CYCLES(MS)) bmss_startup_seq_i (.mclk(mclk), .rst_n(rst_n),
      .thermistor_wake_pin(therm), .load_sense_pin(ld), .shutdown_req(sd),
      .conversion_speed_select(spd), .autonomous_switch_control(sw),
      .aux_reg_autonomous(aux_en), .alarm_select(sel), .aux_regulator_output(aux_o),
      .boot_started_flag(st_f), .boot_done_flag(dn_f), .conversion_pass_flag(cv_f),
      .full_measurement_pass_flag(fl_f), .normal_mode(nm_o), .protection_switch_on(sw_o),
      .alarm_o(al_o), .alarm_oe_n(al_oe_n));
   bmss_host_model bmss_host_model_i (.mclk(mclk), .alarm_o(al_o), .alarm_oe_n(al_oe_n),
      .alarm_line(alarm_line));
   // ****************************************
   // clock, cycle count, helpers
   // ****************************************
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // edge index used to time the marks
   always @(posedge mclk) cyc <= cyc + 32'h1;
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // edge at which a mark of n ms is due
   function automatic logic [31:0] due(input logic [31:0] e0, input logic [31:0] n);
      return (n === NONE) ? NONE : e0 + 32'h2 + n * MS;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] tol);
      n_compared++;
      if ((seen + tol - exp <= 2 * tol) !== 1'b1)
      begin
         bad_count++;
         $display("[ERR] %0t seen %0d expected %0d", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ****************************************
   // one wake-to-switch run
   // ****************************************
   task automatic run(input logic s, input logic a, input logic [1:0] m, input logic [1:0] al,
      input logic w);
      logic [31:0] rise [7];
      logic [31:0] ms [7];
      logic [31:0] e0;
      logic [31:0] fall;
      logic [31:0] al_due;
      spd = s;
      aux_en = a;
      sw = (m == 2'h1);
      sel = al;
      sd = 1'b1;
      therm = w;
      ld = w;
      repeat (4) @(negedge mclk);
      chk({25'h0, outs}, 32'h0, 32'h0);
      sd = 1'b0;
      e0 = cyc + 32'h1;
      foreach (rise[j]) rise[j] = NONE;
      fall = NONE;
      ms = '{a ? 32'd20 : NONE, 32'd23, s ? 32'd35 : 32'd47, s ? 32'd35 : 32'd47,
         s ? 32'd62 : 32'd97, s ? 32'd62 : 32'd97,
         (m == 2'h1) ? 32'd278 : (m == 2'h2) ? 32'd528 : NONE};
      repeat (541 * MS)
      begin
         @(negedge mclk);
         if (m == 2'h2 && cyc == e0 + 300 * MS)
            sw = 1'b1;
         foreach (rise[j]) if (outs[j] === 1'b1 && rise[j] === NONE) rise[j] = cyc;
         // host sees the pin one edge after the device pulls it low
         if (alarm_line === 1'b0 && fall === NONE) fall = cyc;
      end
      foreach (ms[j]) chk(rise[j], due(e0, ms[j]), (ms[j] === NONE) ? 0 : 1);
      chk(rise[3], rise[2], 32'h0);
      chk({31'h0, alarm_line}, {31'h0, al == 2'h0}, 32'h0);
      al_due = (al == 2'h0) ? NONE :
         due(e0, (al == 2'h1) ? ms[1] : (al == 2'h2) ? ms[2] : ms[4]) + 32'h1;
      chk(fall, al_due, (al == 2'h0) ? 0 : 1);
      $display("run end speed %0d mode %0d alarm %0d", s, m, al);
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial
   begin
      {therm, ld, sd, spd, sw, aux_en, sel, rst_n} = 9'h100;
      seed = 32'd49;
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      run(1'b0, 1'b1, 2'h1, 2'h1, 1'b0);
      run(1'b1, 1'b1, 2'h2, 2'h3, 1'b1);
      run(1'b0, 1'b0, 2'h0, 2'h2, 1'b1);
      // corner: a shutdown that cuts a boot short after the early marks
      aux_en = 1'b1;
      sd = 1'b1;
      repeat (4) @(negedge mclk);
      sd = 1'b0;
      repeat (30 * MS) @(negedge mclk);
      chk({25'h0, outs}, 32'h3, 32'h0);
      $display("cut boot end");
      repeat (3)
      begin
         seed = xs(seed);
         run(seed[0], seed[1], (seed[3:2] == 2'h3) ? 2'h1 : seed[3:2], seed[5:4], seed[6]);
      end
      rst_n = 1'b0;
      @(negedge mclk);
      chk({24'h0, outs, al_oe_n}, 32'h1, 32'h0);
      test_done();
   end
   // cut a hang short well past the expected run length
   initial
   begin
      #120000;
      bad_count++;
      test_done();
   end
endmodule // tb
`default_nettype wire
